// [pdc_pkg.sv]
// Purpose: shared constants and carrier types of the pll divider config logic
// Assumes: 100 MHz mclk, all configuration pins asynchronous to mclk
// Notes: field positions of the serial word and of the status word live here
package pdc_pkg;

    // ****************************************
    // widths and serial word layout
    // ****************************************
    localparam int M_W = 9;
    localparam int N_W = 2;
    localparam int T_W = 3;
    localparam int SR_W = 14;
    localparam int SR_M_LSB = 0;
    localparam int SR_N_LSB = 9;
    localparam int SR_T_LSB = 11;

    // ****************************************
    // divider codes
    // ****************************************
    localparam logic [2:0] REF_HALF_LAST = 3'h7;
    localparam logic [1:0] N_DIV1 = 2'h3;
    localparam logic [1:0] N_DIV2 = 2'h0;
    localparam logic [1:0] N_DIV4 = 2'h1;
    localparam logic [1:0] N_DIV8 = 2'h2;

    // ****************************************
    // probe select codes
    // ****************************************
    localparam logic [2:0] T_OFF = 3'h0;
    localparam logic [2:0] T_REF = 3'h1;
    localparam logic [2:0] T_FB = 3'h2;
    localparam logic [2:0] T_VCO = 3'h3;
    localparam logic [2:0] T_FOUT = 3'h4;
    localparam logic [2:0] T_OSC = 3'h5;
    localparam logic [2:0] T_SCLK = 3'h6;
    localparam logic [2:0] T_SHIFT = 3'h7;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_MHZ = 100;
    localparam int LOCK_TIME_MS = 10;
    localparam int LOCK_CYCLES = LOCK_TIME_MS * 1000 * CLK_MHZ;
    localparam int SETTLE_W = 20;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_STATUS = 8'h04;
    localparam logic [7:0] ADR_SHIFT = 8'h08;
    localparam int CTRL_RUN_BIT = 0;
    localparam logic CTRL_RUN_RST = 1'b1;
    localparam int ST_M_LSB = 0;
    localparam int ST_N_LSB = 9;
    localparam int ST_T_LSB = 11;
    localparam int ST_SER_BIT = 14;
    localparam int ST_PLOAD_BIT = 15;
    localparam int ST_SETTLE_BIT = 16;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic [M_W-1:0] m;
        logic [N_W-1:0] n;
        logic par_load;
        logic ser_clk;
        logic ser_data;
        logic ser_load;
        logic ref_osc;
        logic vco_clk;
    } pdc_pins_t;

    // pulled-up pins read one until the pad says otherwise
    localparam pdc_pins_t PIN_RST = '{m: 9'h1ff, n: 2'h3, default: 1'b0};

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } pdc_wb_req_t;

endpackage

// [pdc_sync.sv]
// Purpose: two flop synchroniser for a bundle of asynchronous levels
// Assumes: each bit is a level held long enough to be seen by mclk
// Notes: first stage feeds the second stage only
`timescale 1ns/100ps
module pdc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [1:0][W-1:0] st_reg;
    logic [1:0][W-1:0] st_next;

    always_comb begin
        st_next = {st_reg[0], d};
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= {RST, RST};
        end else begin
            st_reg <= st_next;
        end
    end

    assign q = st_reg[1];

endmodule

// [pdc_core.sv]
// Purpose: configuration latches, shift register and digital dividers of a pll synthesizer
// Assumes: pins asynchronous to mclk; vco and reference are modelled as slow sampled levels
// Notes: wishbone classic slave with control, status and shift readback registers
`timescale 1ns/100ps

// Contract
// - reference divided by fixed sixteen
// - vco divided by feedback divisor
// - post divider ratio one two four eight
// - post divider output fifty percent duty
// - parallel strobe rise captures M and N pins
// - parallel path overrides serial commits
// - undriven divisor pins read as one
// - fourteen bit shift on serial clock rise
// - serial strobe fall commits when parallel high
// - probe select bits pick observation node
// - divisor is plain unsigned binary
// - serial order probe, post, divisor, msb first
// - parallel latches transparent while strobe low
// - probe bits forced zero while strobe low
// - post codes 11=1 00=2 01=4 10=8
module pdc_core #(
    parameter int LOCK_CYC = pdc_pkg::LOCK_CYCLES
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire pdc_pkg::pdc_pins_t pins,
    input wire pdc_pkg::pdc_wb_req_t wb_req,
    output logic wb_ack,
    output logic [31:0] wb_dat_r,
    output logic pd_ref,
    output logic pd_fb,
    output logic fout,
    output logic test_node
);
    import pdc_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        pdc_pins_t pin_q;
        logic [SR_W-1:0] shift;
        logic [M_W-1:0] m_act;
        logic [N_W-1:0] n_act;
        logic [T_W-1:0] t_act;
        logic ser_cfg;
        logic [2:0] ref_cnt;
        logic ref_out;
        logic [M_W-1:0] fb_cnt;
        logic fb_out;
        logic [2:0] post_cnt;
        logic fout;
        logic test_node;
        logic run;
        logic [SETTLE_W-1:0] settle;
        logic ack;
        logic [31:0] dat_r;
    } pdc_state_t;

    pdc_state_t st_reg;
    pdc_state_t st_next;
    pdc_pins_t p;
    logic sclk_rise;
    logic sload_fall;
    logic pl_rise;
    logic ref_rise;
    logic vco_rise;
    logic cfg_par;
    logic cfg_ser;
    logic wb_hit;

    // pad pullups resolve undriven M/N pins high; the sync resets to ones too
    pdc_sync #(
        .W($bits(pdc_pins_t)),
        .RST(PIN_RST)
    ) u_sync (
        .mclk(mclk),
        .rst_b(rst_b),
        .d(pins),
        .q(p)
    );

    // ****************************************
    // edge detection on synchronised pins
    // ****************************************
    assign sclk_rise = p.ser_clk & ~st_reg.pin_q.ser_clk;
    assign sload_fall = ~p.ser_load & st_reg.pin_q.ser_load;
    assign pl_rise = p.par_load & ~st_reg.pin_q.par_load;
    assign ref_rise = p.ref_osc & ~st_reg.pin_q.ref_osc;
    assign vco_rise = p.vco_clk & ~st_reg.pin_q.vco_clk;
    assign cfg_par = ~p.par_load | pl_rise;
    assign cfg_ser = ~cfg_par & sload_fall;
    assign wb_hit = wb_req.cyc & wb_req.stb;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        st_next = st_reg;
        st_next.pin_q = p;

        // first bit sent ends up at the top: T2 first, M0 last
        if (sclk_rise) begin
            st_next.shift = {st_reg.shift[SR_W-2:0], p.ser_data};
        end

        // low strobe: transparent; rising edge: final capture
        if (cfg_par) begin
            st_next.m_act = p.m;
            st_next.n_act = p.n;
            st_next.t_act = T_OFF;
            st_next.ser_cfg = 1'b0;
        end else if (cfg_ser) begin
            // shift register itself is left as is
            st_next.m_act = st_reg.shift[SR_M_LSB +: M_W];
            st_next.n_act = st_reg.shift[SR_N_LSB +: N_W];
            st_next.t_act = st_reg.shift[SR_T_LSB +: T_W];
            st_next.ser_cfg = 1'b1;
        end

        // status hint for software; the loop itself gets no reset here
        if (st_next.m_act != st_reg.m_act || st_next.n_act != st_reg.n_act) begin
            st_next.settle = SETTLE_W'(LOCK_CYC);
        end else if (st_reg.settle != '0) begin
            st_next.settle = st_reg.settle - 1'b1;
        end

        if (!st_reg.run) begin
            st_next.ref_cnt = '0;
            st_next.ref_out = 1'b0;
            st_next.fb_cnt = '0;
            st_next.fb_out = 1'b0;
            st_next.post_cnt = '0;
            st_next.fout = 1'b0;
        end else begin
            // toggle every eighth rise gives a divide by sixteen
            if (ref_rise) begin
                if (st_reg.ref_cnt == REF_HALF_LAST) begin
                    st_next.ref_cnt = '0;
                    st_next.ref_out = ~st_reg.ref_out;
                end else begin
                    st_next.ref_cnt = st_reg.ref_cnt + 1'b1;
                end
            end
            // unsigned binary modulus; high for the first half of each period
            if (vco_rise) begin
                if (st_reg.fb_cnt >= st_reg.m_act - 1'b1) begin
                    st_next.fb_cnt = '0;
                end else begin
                    st_next.fb_cnt = st_reg.fb_cnt + 1'b1;
                end
                st_next.post_cnt = st_reg.post_cnt + 1'b1;
            end
            st_next.fb_out = st_next.fb_cnt < (st_reg.m_act >> 1);
            // binary counter bits are exact half-duty divides
            case (st_reg.n_act)
                N_DIV1: st_next.fout = p.vco_clk;
                N_DIV2: st_next.fout = st_next.post_cnt[0];
                N_DIV4: st_next.fout = st_next.post_cnt[1];
                N_DIV8: st_next.fout = st_next.post_cnt[2];
                default: st_next.fout = 1'b0;
            endcase
        end

        // kept static when off so the output pair stays clean
        case (st_reg.t_act)
            T_OFF: st_next.test_node = 1'b0;
            T_REF: st_next.test_node = st_reg.ref_out;
            T_FB: st_next.test_node = st_reg.fb_out;
            T_VCO: st_next.test_node = p.vco_clk;
            T_FOUT: st_next.test_node = st_reg.fout;
            T_OSC: st_next.test_node = p.ref_osc;
            T_SCLK: st_next.test_node = p.ser_clk;
            T_SHIFT: st_next.test_node = st_reg.shift[SR_W-1];
            default: st_next.test_node = 1'b0;
        endcase

        // ****************************************
        // wishbone classic slave
        // ****************************************
        st_next.ack = wb_hit & ~st_reg.ack;
        if (wb_hit && !st_reg.ack) begin
            st_next.dat_r = '0;
            case (wb_req.adr)
                ADR_CTRL: st_next.dat_r[CTRL_RUN_BIT] = st_reg.run;
                ADR_STATUS: begin
                    st_next.dat_r[ST_M_LSB +: M_W] = st_reg.m_act;
                    st_next.dat_r[ST_N_LSB +: N_W] = st_reg.n_act;
                    st_next.dat_r[ST_T_LSB +: T_W] = st_reg.t_act;
                    st_next.dat_r[ST_SER_BIT] = st_reg.ser_cfg;
                    st_next.dat_r[ST_PLOAD_BIT] = p.par_load;
                    st_next.dat_r[ST_SETTLE_BIT] = st_reg.settle != '0;
                end
                ADR_SHIFT: st_next.dat_r[SR_W-1:0] = st_reg.shift;
                default: st_next.dat_r = '0;
            endcase
        end
        // write lands on the edge where the master sees ack
        if (wb_hit && st_reg.ack && wb_req.we && wb_req.sel[0] && wb_req.adr == ADR_CTRL) begin
            st_next.run = wb_req.dat[CTRL_RUN_BIT];
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= '{pin_q: PIN_RST, m_act: PIN_RST.m, n_act: PIN_RST.n, run: CTRL_RUN_RST,
                        default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign wb_ack = st_reg.ack;
    assign wb_dat_r = st_reg.dat_r;
    assign pd_ref = st_reg.ref_out;
    assign pd_fb = st_reg.fb_out;
    assign fout = st_reg.fout;
    assign test_node = st_reg.test_node;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    AST_REF_SIXTEEN:
    assert property ($changed(st_reg.ref_out) && $past(st_reg.run) |->
                     $past(ref_rise) && $past(st_reg.ref_cnt) == 3'h7)
        else $error("reference output toggled off the eighth edge");

    AST_FB_WRAP:
    assert property (st_reg.run && vco_rise && !cfg_par && !cfg_ser &&
                     st_reg.fb_cnt >= st_reg.m_act - 1'b1 |=> st_reg.fb_cnt == 9'h000)
        else $error("feedback counter did not wrap at the divisor");

    AST_DIV2_TOGGLE:
    assert property (st_reg.run && st_reg.n_act == 2'h0 && $stable(st_reg.n_act) && vco_rise &&
                     !cfg_par && !cfg_ser |=> st_reg.fout != $past(st_reg.fout))
        else $error("divide by two output missed a toggle");

    AST_PAR_CAPTURE:
    assert property (pl_rise |=> st_reg.m_act == $past(p.m) && st_reg.n_act == $past(p.n))
        else $error("parallel strobe rise did not capture the pins");

    AST_PAR_PRIORITY:
    assert property (sload_fall && !p.par_load |=> st_reg.m_act == $past(p.m) && !st_reg.ser_cfg)
        else $error("serial commit acted while parallel path in control");

    AST_TRANSPARENT_T0:
    assert property (!p.par_load |=> st_reg.t_act == 3'h0 ##1 st_reg.test_node == 1'b0)
        else $error("probe select not forced to zero");

    AST_SHIFT_IN:
    assert property (sclk_rise |=> st_reg.shift == {$past(st_reg.shift[12:0]), $past(p.ser_data)})
        else $error("shift register did not advance by one");

    AST_SER_COMMIT:
    assert property (cfg_ser |=> st_reg.m_act == $past(st_reg.shift[8:0]) &&
                     st_reg.n_act == $past(st_reg.shift[10:9]) &&
                     st_reg.t_act == $past(st_reg.shift[13:11]))
        else $error("serial commit did not copy the shift register");

    AST_CFG_HOLD:
    assert property (p.par_load && !pl_rise && !sload_fall |=>
                     $stable(st_reg.m_act) && $stable(st_reg.n_act) && $stable(st_reg.t_act))
        else $error("active divisor changed without a commit");

    AST_ACK_ONE:
    assert property (wb_hit && !st_reg.ack |=> st_reg.ack ##1 !st_reg.ack)
        else $error("wishbone ack not a single cycle answer");

    AST_REF_HOLD:
    assert property (st_reg.run && !ref_rise |=>
                     $stable(st_reg.ref_cnt) && $stable(st_reg.ref_out))
        else $error("reference divider moved without a reference edge");

    AST_FB_HOLD:
    assert property (st_reg.run && !vco_rise |=> $stable(st_reg.fb_cnt))
        else $error("feedback counter moved without a vco edge");

    AST_DIV1_FOLLOW:
    assert property (st_reg.run && st_reg.n_act == 2'h3 |=>
                     st_reg.fout == $past(p.vco_clk))
        else $error("divide by one output does not follow the vco");

    AST_DIV8_HOLD:
    assert property (st_reg.run && st_reg.n_act == 2'h2 && $stable(st_reg.n_act) && !vco_rise
                     |=> $stable(st_reg.fout))
        else $error("divide by eight output moved without a vco edge");

    AST_SETTLE_LOAD:
    assert property ($changed(st_reg.m_act) || $changed(st_reg.n_act) |->
                     st_reg.settle == SETTLE_W'(LOCK_CYC))
        else $error("settle counter not reloaded on a divisor change");

    AST_PROBE_REF:
    assert property (st_reg.t_act == T_REF |=> st_reg.test_node == $past(st_reg.ref_out))
        else $error("probe output does not follow the reference divider");

endmodule

// [pdc_ctl_model.sv]
// Purpose: behavioural board controller driving divisor, strobe and serial pins
// Assumes: link clock of 125 ns period, free of any mclk phase
// Notes: idle divisor pins drive ones, as the pad pull-ups would
`timescale 1ns/100ps
module pdc_ctl_model (
    input wire logic mclk,
    output logic [pdc_pkg::M_W-1:0] m,
    output logic [pdc_pkg::N_W-1:0] n,
    output logic par_load,
    output logic ser_clk,
    output logic ser_data,
    output logic ser_load
);
    import pdc_pkg::*;

    // ****************************************
    // power-up levels
    // ****************************************
    initial begin
        m = 9'h1ff;
        n = 2'h3;
        par_load = 1'b0;
        ser_clk = 1'b0;
        ser_data = 1'b0;
        ser_load = 1'b0;
    end

    // ****************************************
    // parallel path
    // ****************************************
    task par_set(input logic [8:0] mv, input logic [1:0] nv);
        @(posedge mclk);
        m <= mv;
        n <= nv;
    endtask

    task par_strobe(input logic lv);
        @(posedge mclk);
        par_load <= lv;
    endtask

    // ****************************************
    // serial path
    // ****************************************
    task ser_send(input logic [2:0] t, input logic [1:0] nv, input logic [8:0] mv);
        logic [13:0] w;
        int i;
        w = {t, nv, mv};
        #3.7;
        // 125 ns period keeps the shift clock under the divisor load limit
        for (i = 13; i >= 0; i--) begin
            ser_data = w[i];
            #62.5 ser_clk = 1'b1;
            #62.5 ser_clk = 1'b0;
        end
        // hold time spent: line no longer shows the last bit
        ser_data = ~ser_data;
        #62.5 ser_load = 1'b1;
        #62.5 ser_load = 1'b0;
    endtask
endmodule

// [tb_top.sv]
// Purpose: self-checking bench for the pll divider config logic
// Assumes: ref level period 8 mclk cycles, vco level period 6 mclk cycles
// Notes: lock count shortened to 50 cycles
`timescale 1ns/100ps
module tb_top;
    import pdc_pkg::*;
    logic mclk;
    logic rst_b;
    logic ref_osc;
    logic vco_clk;
    logic [8:0] c_m;
    logic [1:0] c_n;
    logic c_pl, c_sc, c_sd, c_sl;
    pdc_pins_t pins;
    pdc_wb_req_t wb_req;
    logic wb_ack;
    logic [31:0] wb_dat_r;
    logic pd_ref, pd_fb, fout, test_node, sig;
    logic [31:0] d;
    logic [1:0] codes [4] = '{N_DIV1, N_DIV2, N_DIV4, N_DIV8};
    logic [2:0] probes [4] = '{T_FB, T_VCO, T_OSC, T_FOUT};
    int pper [4] = '{36, 6, 8, 48};
    int fail_count, total_checks, sel, rc, vc, per, hi, k, j;

    assign pins = '{m: c_m, n: c_n, par_load: c_pl, ser_clk: c_sc, ser_data: c_sd,
                    ser_load: c_sl, ref_osc: ref_osc, vco_clk: vco_clk};
    assign sig = (sel == 0) ? pd_ref : (sel == 1) ? pd_fb : (sel == 2) ? fout : test_node;

    pdc_core #(.LOCK_CYC(50)) dut (.mclk(mclk), .rst_b(rst_b), .pins(pins),
        .wb_req(wb_req), .wb_ack(wb_ack), .wb_dat_r(wb_dat_r), .pd_ref(pd_ref),
        .pd_fb(pd_fb), .fout(fout), .test_node(test_node));

    pdc_ctl_model ctl (.mclk(mclk), .m(c_m), .n(c_n), .par_load(c_pl), .ser_clk(c_sc),
        .ser_data(c_sd), .ser_load(c_sl));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial begin
        ref_osc = 1'b0;
        vco_clk = 1'b0;
        rc = 0;
        vc = 0;
    end

    always @(posedge mclk) begin
        rc <= (rc == 3) ? 0 : rc + 1;
        vc <= (vc == 2) ? 0 : vc + 1;
        if (rc == 3)
            ref_osc <= ~ref_osc;
        if (vc == 2)
            vco_clk <= ~vco_clk;
    end

    // ****************************************
    // helpers
    // ****************************************
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task wb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        int t;
        t = 0;
        @(posedge mclk);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: wd};
        do begin
            @(posedge mclk);
            t++;
        end while (wb_ack !== 1'b1);
        rd = wb_dat_r;
        chk("ack wait", 32'd2, t);
        wb_req <= '0;
    endtask

    task rdc(input string nm, input logic [7:0] a, input logic [31:0] mk, input logic [31:0] e);
        wb(1'b0, a, 32'h0, d);
        chk(nm, e, d & mk);
    endtask

    // period and high time in mclk cycles, rise to rise
    task meas(input int s, output int p, output int h);
        logic q;
        sel = s;
        p = 0;
        h = 0;
        k = 0;
        @(posedge mclk);
        q = sig;
        @(posedge mclk);
        while (!(q === 1'b0 && sig === 1'b1) && k < 400) begin
            q = sig;
            @(posedge mclk);
            k++;
        end
        do begin
            p++;
            h += (sig === 1'b1);
            q = sig;
            @(posedge mclk);
        end while (!(q === 1'b0 && sig === 1'b1) && p < 400);
    endtask

    task end_sim;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        end_sim;
    end

    // ****************************************
    // tests
    // ****************************************
    initial begin
        rst_b = 1'b0;
        wb_req = '0;
        fail_count = 0;
        total_checks = 0;
        sel = 0;
        repeat (12) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (4) @(posedge mclk);
        rdc("reset", ADR_STATUS, 32'h3fff, {18'h0, T_OFF, 2'h3, 9'h1ff});
        rdc("unmapped", 8'h0c, 32'hffffffff, 32'h0);
        wb(1'b1, ADR_CTRL, 32'h0, d);
        rdc("ctrl", ADR_CTRL, 32'h1, 32'h0);
        wb(1'b1, ADR_CTRL, 32'h1, d);
        ctl.par_set(9'd200, N_DIV2);
        repeat (6) @(posedge mclk);
        rdc("open", ADR_STATUS, 32'h1ffff,
            {15'h0, 3'h4, T_OFF, N_DIV2, 9'd200});
        ctl.par_set(9'h106, N_DIV4);
        repeat (3) @(posedge mclk);
        ctl.par_strobe(1'b1);
        repeat (3) @(posedge mclk);
        ctl.par_set(9'h005, N_DIV8);
        repeat (6) @(posedge mclk);
        rdc("capture", ADR_STATUS, 32'hffff, {16'h0, 2'h2, T_OFF, N_DIV4, 9'h106});
        ctl.ser_send(T_REF, N_DIV8, 9'd6);
        repeat (8) @(posedge mclk);
        rdc("serial", ADR_STATUS, 32'h7fff, {17'h0, 1'b1, T_REF, N_DIV8, 9'd6});
        rdc("shift", ADR_SHIFT, 32'h3fff, {18'h0, T_REF, N_DIV8, 9'd6});
        meas(3, per, hi);
        chk("probe per", 32'd128, per);
        meas(0, per, hi);
        chk("ref per", 32'd128, per);
        chk("ref high", 32'd64, hi);
        meas(1, per, hi);
        chk("fb per", 32'd36, per);
        chk("fb high", 32'd18, hi);
        for (j = 0; j < 4; j++) begin
            ctl.ser_send(T_OFF, codes[j], 9'd6);
            repeat (8) @(posedge mclk);
            meas(2, per, hi);
            chk("fout per", 32'd6 << j, per);
            chk("fout high", 32'd3 << j, hi);
        end
        chk("probe off", 32'h0, {31'h0, test_node});
        for (j = 0; j < 4; j++) begin
            ctl.ser_send(probes[j], N_DIV8, 9'd6);
            repeat (8) @(posedge mclk);
            meas(3, per, hi);
            chk("probe node per", pper[j], per);
        end
        ctl.ser_send(T_SHIFT, N_DIV8, 9'd6);
        repeat (8) @(posedge mclk);
        chk("probe msb", 32'h1, {31'h0, test_node});
        ctl.par_strobe(1'b0);
        repeat (6) @(posedge mclk);
        rdc("low", ADR_STATUS, 32'h1ffff,
            {15'h0, 3'h4, T_OFF, N_DIV8, 9'h005});
        chk("probe low", 32'h0, {31'h0, test_node});
        ctl.ser_send(T_FB, N_DIV1, 9'd7);
        repeat (8) @(posedge mclk);
        rdc("ignored", ADR_STATUS, 32'h1ffff,
            {15'h0, 3'h0, T_OFF, N_DIV8, 9'h005});
        end_sim;
    end
endmodule
